// >>> logic/fbr_pkg.sv
`default_nettype none

package fbr_pkg;
  // Instruction codes.
  localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
  localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
  localparam logic [7:0] CLEAR_FAIL_FLAGS_CMD = 8'h30;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] BOOT_REG_READ_CMD = 8'h14;
  localparam logic [7:0] BOOT_REG_WRITE_CMD = 8'h15;
  localparam logic [7:0] READ_CMD = 8'h03;
  localparam logic [7:0] FOUR_BYTE_READ_CMD = 8'h13;

  // Bit positions in status_register_one.
  localparam int SR_IN_PROGRESS = 0;
  localparam int SR_WRITE_LATCH = 1;
  localparam int SR_ERASE_FAIL = 5;
  localparam int SR_PROGRAM_FAIL = 6;

  // Fields of boot_read_config.
  localparam int BOOT_ENABLE_BIT = 0;
  localparam int BOOT_DELAY_LSB = 1;
  localparam int BOOT_DELAY_W = 8;
  localparam int BOOT_ADDR_LSB = 9;
  localparam int BOOT_ADDR_W = 23;
  localparam logic [31:0] BOOT_REG_RESET = 32'h0000_0000;

  // Array geometry: only A23..A0 reach the array.
  localparam int ARRAY_ADDR_W = 24;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 16;

  // Serial bit counts.
  localparam logic [5:0] LAST_CMD_BIT = 6'h07;
  localparam logic [5:0] LAST_ADDR3_BIT = 6'h17;
  localparam logic [5:0] LAST_ADDR4_BIT = 6'h1F;
  localparam logic [5:0] LAST_DATA_BIT = 6'h1F;

  // Self-timed boot register update.
  localparam int CLK_PERIOD_NS = 10;
  localparam int UPD_TIME_US = 100;
  localparam int UPD_CYCLES = (UPD_TIME_US * 1000) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_ARM, ST_WDATA, ST_WARM, ST_DELAY, ST_DATA
  } fbr_state_t;
  localparam fbr_state_t ST_IGNORE = ST_IDLE;
endpackage

`default_nettype wire

// >>> logic/fbr_boot_read.sv
// Summary of operation
// - Write-disable 04h clears the write enable latch.
// - Write-disable ignored while operation in progress.
// - Write-disable needs chip select after eighth bit.
// - Clear-status 30h resets erase and program fail.
// - Clear-status needs no latch, works while busy.
// - Enabled boot read starts fetching at reset.
// - Boot data waits the start-delay clock count.
// - Boot address: 23 bits, 512-byte aligned, default zero.
// - Boot data streams until chip select rises.
// - Boot read never repeats until next reset.
// - Quad enable gives four-bit boot data.
// - Boot register read 14h: low byte first.
// - Boot register read repeats every 32 cycles.
// - Boot register write 15h needs write latch.
// - Write runs on chip select after 32nd bit.
// - Update end clears latch and in-progress flag.
// - Update failure sets erase or program fail.
// - Address bits above A23 are ignored.
// - Chip select rise ends any read.
// - Read 03h takes 3/4 bytes, 13h four.
// - Read address increments and wraps to zero.
// - Write-enable 06h sets the write enable latch.
`default_nettype none

module fbr_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least two");
  end
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fbr_fifo_st_t;
  fbr_fifo_st_t q;
  fbr_fifo_st_t d;
  logic push;
  logic pop;

  assign in_ready = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    d = q;
    if (flush) begin
      d.wr = '0;
      d.rd = '0;
      d.cnt = '0;
    end else begin
      if (push) begin
        d.mem[q.wr] = in_data;
        d.wr = q.wr + 1'b1;
      end
      if (pop) begin
        d.rd = q.rd + 1'b1;
      end
      d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

module fbr_boot_read #(
  parameter int UPD_CYCLES = fbr_pkg::UPD_CYCLES,
  parameter logic [31:0] BOOT_REG_INIT = fbr_pkg::BOOT_REG_RESET
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Serial pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe,
  // Device configuration and embedded operations
  input wire logic quad_enable,
  input wire logic four_byte_address_mode,
  input wire logic ext_busy,
  input wire logic upd_erase_fail,
  input wire logic upd_program_fail,
  // Array read port
  output logic arr_req,
  output logic [fbr_pkg::ARRAY_ADDR_W-1:0] arr_addr,
  input wire logic arr_ack,
  input wire logic [7:0] arr_data,
  // Visible state
  output logic [7:0] status_one,
  output logic [31:0] boot_read_config
);
  localparam int UCW = $clog2(UPD_CYCLES + 1);
  localparam int CS = 2;
  localparam int CK = 1;
  localparam int SI = 0;
  if (UPD_CYCLES < 1) begin : g_bad_upd
    $error("UPD_CYCLES must be at least one");
  end

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    fbr_pkg::fbr_state_t st;
    logic [5:0] bits;
    logic [31:0] sr;
    logic [7:0] op;
    logic long_addr;
    logic [7:0] out_sr;
    logic [2:0] out_cnt;
    logic [1:0] src;
    logic [1:0] byte_idx;
    logic [7:0] dly;
    logic wide;
    logic boot_go;
    logic boot_pend;
    logic [31:0] boot_reg;
    logic [31:0] new_reg;
    logic wr_latch;
    logic efail;
    logic pfail;
    logic upd_busy;
    logic [UCW-1:0] upd_cnt;
    logic f_act;
    logic f_req;
    logic f_drop;
    logic [fbr_pkg::ARRAY_ADDR_W-1:0] f_addr;
    logic [3:0] io_o;
    logic [3:0] io_oe;
  } fbr_st_t;

  // Synchronisers start at the idle pin levels so that no false edge follows reset.
  localparam fbr_st_t RESET_ST = '{st: fbr_pkg::ST_IDLE, s1: 3'h4, s2: 3'h4, s3: 3'h4,
    boot_go: 1'b1, boot_pend: 1'b1, boot_reg: BOOT_REG_INIT, default: '0};
  localparam logic [1:0] SRC_FIFO = 2'h0;
  localparam logic [1:0] SRC_BOOT = 2'h1;
  localparam logic [1:0] SRC_STAT = 2'h2;

  fbr_st_t q;
  fbr_st_t d;
  logic cs_rise;
  logic cs_fall;
  logic sck_rise;
  logic sck_fall;
  logic op_busy;
  logic [7:0] op_in;
  logic upd_end;
  logic load;
  logic pop;
  logic restart;
  logic flush;
  logic [fbr_pkg::ARRAY_ADDR_W-1:0] new_addr;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;

  function automatic logic [31:0] byte_swap(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction

  function automatic logic [7:0] status_byte(input fbr_st_t s, input logic busy);
    logic [7:0] r;
    r = 8'h00;
    r[fbr_pkg::SR_IN_PROGRESS] = busy;
    r[fbr_pkg::SR_WRITE_LATCH] = s.wr_latch;
    r[fbr_pkg::SR_ERASE_FAIL] = s.efail;
    r[fbr_pkg::SR_PROGRAM_FAIL] = s.pfail;
    return r;
  endfunction

  // Edges are taken from the second and third stages only.
  assign cs_rise = !q.s3[CS] && q.s2[CS];
  assign cs_fall = q.s3[CS] && !q.s2[CS];
  assign sck_rise = !q.s3[CK] && q.s2[CK];
  assign sck_fall = q.s3[CK] && !q.s2[CK];
  assign op_busy = q.upd_busy || ext_busy;
  assign op_in = {q.sr[6:0], q.s2[SI]};
  assign upd_end = q.upd_busy && (q.upd_cnt == '0);
  assign flush = cs_rise || restart;
  assign fifo_in_valid = q.f_req && arr_ack && !q.f_drop && !flush;

  always_comb begin
    d = q;
    load = 1'b0;
    pop = 1'b0;
    restart = 1'b0;
    new_addr = q.f_addr;
    d.s1 = {cs_n, sck, io_i[0]};
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.boot_go) begin
      d.boot_go = 1'b0;
      if (q.boot_reg[fbr_pkg::BOOT_ENABLE_BIT]) begin
        restart = 1'b1;
        new_addr = q.boot_reg[fbr_pkg::ARRAY_ADDR_W-1:0] & {{15{1'b1}}, 9'h000};
      end else begin
        d.boot_pend = 1'b0;
      end
    end
    if (cs_rise) begin
      if (q.st == fbr_pkg::ST_ARM) begin
        case (q.op)
          fbr_pkg::CLEAR_WRITE_LATCH_CMD: if (!op_busy) d.wr_latch = 1'b0;
          fbr_pkg::SET_WRITE_LATCH_CMD: d.wr_latch = 1'b1;
          fbr_pkg::CLEAR_FAIL_FLAGS_CMD: begin
            d.efail = 1'b0;
            d.pfail = 1'b0;
          end
          default: ;
        endcase
      end else if (q.st == fbr_pkg::ST_WARM) begin
        d.upd_busy = 1'b1;
        d.upd_cnt = UCW'(UPD_CYCLES - 1);
      end
      if (q.st != fbr_pkg::ST_IDLE) begin
        d.boot_pend = 1'b0;
      end
      d.st = fbr_pkg::ST_IDLE;
      d.f_act = 1'b0;
    end else if (cs_fall) begin
      d.bits = '0;
      if (q.boot_pend) begin
        d.wide = quad_enable;
        d.src = SRC_FIFO;
        d.dly = q.boot_reg[fbr_pkg::BOOT_DELAY_LSB +: fbr_pkg::BOOT_DELAY_W];
        if (d.dly == 8'h00) begin
          load = 1'b1;
          d.st = fbr_pkg::ST_DATA;
        end else begin
          d.st = fbr_pkg::ST_DELAY;
        end
      end else begin
        d.st = fbr_pkg::ST_CMD;
      end
    end else if (sck_rise) begin
      d.sr = {q.sr[30:0], q.s2[SI]};
      d.bits = q.bits + 6'h01;
      case (q.st)
        fbr_pkg::ST_CMD: begin
          if (q.bits == fbr_pkg::LAST_CMD_BIT) begin
            d.op = op_in;
            d.bits = '0;
            d.wide = 1'b0;
            d.out_cnt = 3'h7;
            d.byte_idx = 2'h0;
            case (op_in)
              fbr_pkg::STATUS_READ_CMD: begin
                d.st = fbr_pkg::ST_DATA;
                d.src = SRC_STAT;
              end
              fbr_pkg::BOOT_REG_READ_CMD: begin
                d.st = fbr_pkg::ST_DATA;
                d.src = SRC_BOOT;
              end
              fbr_pkg::READ_CMD: begin
                d.st = fbr_pkg::ST_ADDR;
                d.long_addr = four_byte_address_mode;
              end
              fbr_pkg::FOUR_BYTE_READ_CMD: begin
                d.st = fbr_pkg::ST_ADDR;
                d.long_addr = 1'b1;
              end
              fbr_pkg::BOOT_REG_WRITE_CMD: begin
                d.st = q.wr_latch ? fbr_pkg::ST_WDATA : fbr_pkg::ST_IGNORE;
              end
              fbr_pkg::CLEAR_WRITE_LATCH_CMD,
              fbr_pkg::SET_WRITE_LATCH_CMD,
              fbr_pkg::CLEAR_FAIL_FLAGS_CMD: d.st = fbr_pkg::ST_ARM;
              default: d.st = fbr_pkg::ST_IGNORE;
            endcase
          end
        end
        fbr_pkg::ST_ADDR: begin
          if (q.bits == (q.long_addr ? fbr_pkg::LAST_ADDR4_BIT : fbr_pkg::LAST_ADDR3_BIT)) begin
            restart = 1'b1;
            new_addr = d.sr[fbr_pkg::ARRAY_ADDR_W-1:0];
            d.src = SRC_FIFO;
            d.st = fbr_pkg::ST_DATA;
          end
        end
        fbr_pkg::ST_WDATA: begin
          if (q.bits == fbr_pkg::LAST_DATA_BIT) begin
            d.new_reg = byte_swap(d.sr);
            d.st = fbr_pkg::ST_WARM;
          end
        end
        // A ninth bit or a 33rd bit cancels the pending action.
        fbr_pkg::ST_ARM, fbr_pkg::ST_WARM: d.st = fbr_pkg::ST_IGNORE;
        default: ;
      endcase
    end else if (sck_fall) begin
      if (q.st == fbr_pkg::ST_DELAY) begin
        d.dly = q.dly - 8'h01;
        if (q.dly == 8'h01) begin
          load = 1'b1;
          d.st = fbr_pkg::ST_DATA;
        end
      end else if (q.st == fbr_pkg::ST_DATA) begin
        if (q.out_cnt == (q.wide ? 3'h1 : 3'h7)) begin
          load = 1'b1;
        end else begin
          d.out_sr = q.wide ? {q.out_sr[3:0], 4'h0} : {q.out_sr[6:0], 1'b0};
          d.out_cnt = q.out_cnt + 3'h1;
        end
      end
    end
    if (load) begin
      d.out_cnt = 3'h0;
      case (d.src)
        SRC_FIFO: begin
          // An empty FIFO gives the stale entry at the read pointer; the array must keep up.
          d.out_sr = fifo_out_data;
          pop = fifo_out_valid;
        end
        SRC_BOOT: begin
          d.out_sr = q.boot_reg[8*q.byte_idx +: 8];
          d.byte_idx = q.byte_idx + 2'h1;
        end
        default: d.out_sr = status_byte(q, op_busy);
      endcase
    end
    // Array fetch: one request outstanding, issued only with room to land.
    if (flush) begin
      d.f_act = restart;
      d.f_addr = new_addr;
      d.f_drop = q.f_req && !arr_ack;
      d.f_req = q.f_req && !arr_ack;
    end else if (q.f_req && arr_ack) begin
      d.f_req = 1'b0;
      d.f_drop = 1'b0;
      if (!q.f_drop) begin
        d.f_addr = q.f_addr + 24'h000001;
      end
    end else if (q.f_act && !q.f_req && fifo_in_ready) begin
      d.f_req = 1'b1;
    end
    if (upd_end) begin
      d.upd_busy = 1'b0;
      d.wr_latch = 1'b0;
      // Failure flags are set after any clear above, so the set wins.
      d.efail = d.efail || upd_erase_fail;
      d.pfail = d.pfail || upd_program_fail;
      if (!upd_erase_fail && !upd_program_fail) begin
        d.boot_reg = q.new_reg;
      end
    end else if (q.upd_busy) begin
      d.upd_cnt = q.upd_cnt - UCW'(1);
    end
    d.io_oe = 4'h0;
    if (d.st == fbr_pkg::ST_DATA) begin
      d.io_oe = d.wide ? 4'hF : 4'h2;
    end
    d.io_o = d.wide ? d.out_sr[7:4] : {2'h0, d.out_sr[7], 1'b0};
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q <= RESET_ST;
    end else begin
      q <= d;
    end
  end

  fbr_fifo #(.W(fbr_pkg::BYTE_W), .DEPTH(fbr_pkg::FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .flush(flush),
    .in_valid(fifo_in_valid),
    .in_data(arr_data),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(pop)
  );

  assign io_o = q.io_o;
  assign io_oe = q.io_oe;
  assign arr_req = q.f_req;
  assign arr_addr = q.f_addr;
  assign status_one = status_byte(q, q.upd_busy);
  assign boot_read_config = q.boot_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  latch_clear_a: assert property (cs_rise && q.st == fbr_pkg::ST_ARM &&
    q.op == fbr_pkg::CLEAR_WRITE_LATCH_CMD && !op_busy |=> !q.wr_latch)
    else $error("write latch not cleared by write-disable");
  latch_hold_a: assert property (cs_rise && q.st == fbr_pkg::ST_ARM &&
    q.op == fbr_pkg::CLEAR_WRITE_LATCH_CMD && op_busy && !upd_end && q.wr_latch |=> q.wr_latch)
    else $error("write-disable acted while busy");
  arm_late_a: assert property (q.st == fbr_pkg::ST_ARM && sck_rise && !cs_rise
    |=> q.st == fbr_pkg::ST_IDLE)
    else $error("extra clock did not cancel command");
  flags_clear_a: assert property (cs_rise && q.st == fbr_pkg::ST_ARM &&
    q.op == fbr_pkg::CLEAR_FAIL_FLAGS_CMD && !upd_end |=> !q.efail && !q.pfail)
    else $error("fail flags not cleared");
  flags_latch_a: assert property (cs_rise && q.st == fbr_pkg::ST_ARM &&
    q.op == fbr_pkg::CLEAR_FAIL_FLAGS_CMD && !upd_end |=> $stable(q.wr_latch))
    else $error("clear-status changed write latch");
  boot_once_a: assert property (!q.boot_pend |=> !q.boot_pend)
    else $error("boot read re-armed without reset");
  write_reject_a: assert property (sck_rise && !cs_rise && !cs_fall &&
    q.st == fbr_pkg::ST_CMD && q.bits == fbr_pkg::LAST_CMD_BIT &&
    op_in == fbr_pkg::BOOT_REG_WRITE_CMD && !q.wr_latch |=> q.st == fbr_pkg::ST_IDLE)
    else $error("boot register write accepted without latch");
  upd_start_a: assert property (cs_rise && q.st == fbr_pkg::ST_WARM
    |=> q.upd_busy && q.upd_cnt == UCW'(UPD_CYCLES - 1))
    else $error("update did not start on chip select rise");
  upd_done_a: assert property (upd_end |=> !q.wr_latch && !q.upd_busy &&
    (!$past(upd_erase_fail) || q.efail) && (!$past(upd_program_fail) || q.pfail))
    else $error("update end did not clear latch and busy");
  addr_step_a: assert property (q.f_req && arr_ack && !q.f_drop && !flush
    |=> q.f_addr == $past(q.f_addr) + 24'h000001)
    else $error("read address did not advance");
  quad_lanes_a: assert property (q.st == fbr_pkg::ST_DATA && q.wide
    |=> q.st != fbr_pkg::ST_DATA || q.io_oe == 4'hF)
    else $error("quad boot data not on four lanes");
endmodule

`default_nettype wire

// >>> test/fbr_host_model.sv
`default_nettype none

module fbr_host_model (
  // Clock
  input wire logic clk_sys,
  // Device pins
  input wire logic [3:0] io_o,
  input wire logic [3:0] io_oe,
  output logic cs_n,
  output logic sck,
  output logic [3:0] io_i
);
  timeunit 1ns;
  timeprecision 1ns;

  logic si = 1'h0;
  logic drv = 1'h0;
  logic [2:0] float_q = 3'h5;

  initial begin
    cs_n = 1'h1;
    sck = 1'h0;
  end

  // Undriven lanes 3..1 toggle and lane 0 gives the host bit, inverted while the host is silent, so a stale value can never pass for data.
  always @(posedge clk_sys) begin
    float_q <= ~float_q;
  end

  assign io_i = (io_oe & io_o) | (~io_oe & {float_q, drv ? si : ~si});

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic open_frame;
    cs_n = 1'h0;
    tick(4);
  endtask

  // Half period of 8 clocks keeps the serial clock far below its ceiling.
  task automatic bit_cycle(input logic b, input logic drive, output logic [3:0] q);
    si = b;
    drv = drive;
    tick(8);
    sck = 1'h1;
    q = io_i;
    tick(8);
    sck = 1'h0;
  endtask

  // Select rises only after the clock is low again, never inside a cycle.
  task automatic close_frame;
    tick(4);
    cs_n = 1'h1;
    drv = 1'h0;
    tick(8);
  endtask
endmodule

`default_nettype wire

// >>> test/fbr_boot_read_test.sv
`default_nettype none

module fbr_boot_read_test;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [22:0] BOOT_ADDR = 23'h000005;
  localparam logic [7:0] BOOT_DELAY = 8'h02;
  localparam logic [31:0] BOOT_INIT = {BOOT_ADDR, BOOT_DELAY, 1'h1};

  logic clk_sys = 1'h0;
  logic arst_n = 1'h0;
  logic cs_n;
  logic sck;
  logic [3:0] io_i;
  logic [3:0] io_o;
  logic [3:0] io_oe;
  logic quad_enable = 1'h0;
  logic four_byte_address_mode = 1'h0;
  logic ext_busy = 1'h0;
  logic upd_erase_fail = 1'h0;
  logic upd_program_fail = 1'h0;
  logic arr_req;
  logic [23:0] arr_addr;
  logic arr_ack = 1'h0;
  logic [7:0] arr_data = 8'h00;
  logic [7:0] status_one;
  logic [31:0] boot_read_config;
  logic ef_e = 1'h0;
  logic pf_e = 1'h0;
  int n_mismatch = 0;
  int comparisons = 0;
  int seed = 32'h0D939774;
  int ack_wait = 0;

  always #5 clk_sys = ~clk_sys;

  fbr_host_model host (
    .clk_sys(clk_sys),
    .io_o(io_o),
    .io_oe(io_oe),
    .cs_n(cs_n),
    .sck(sck),
    .io_i(io_i)
  );

  fbr_boot_read #(.UPD_CYCLES(20), .BOOT_REG_INIT(BOOT_INIT)) dut (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .cs_n(cs_n),
    .sck(sck),
    .io_i(io_i),
    .io_o(io_o),
    .io_oe(io_oe),
    .quad_enable(quad_enable),
    .four_byte_address_mode(four_byte_address_mode),
    .ext_busy(ext_busy),
    .upd_erase_fail(upd_erase_fail),
    .upd_program_fail(upd_program_fail),
    .arr_req(arr_req),
    .arr_addr(arr_addr),
    .arr_ack(arr_ack),
    .arr_data(arr_data),
    .status_one(status_one),
    .boot_read_config(boot_read_config)
  );

  function automatic logic [7:0] mem_byte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'hA5;
  endfunction

  // Array answers after zero or one idle cycle, fast enough to feed a 03h read.
  always @(negedge clk_sys) begin
    if (arr_ack) begin
      arr_ack <= 1'h0;
      arr_data <= ~arr_data;
    end else if (arr_req && ack_wait == 0) begin
      arr_ack <= 1'h1;
      arr_data <= mem_byte(arr_addr);
      ack_wait <= $random(seed) & 1;
    end else if (arr_req) begin
      ack_wait <= ack_wait - 1;
    end
  end

  task automatic finish_test;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_status(input logic latch, input logic busy);
    chk_byte(status_one, {1'h0, pf_e, ef_e, 3'h0, latch, busy});
  endtask

  task automatic do_reset;
    arst_n = 1'h0;
    host.tick(3);
    arst_n = 1'h1;
    host.tick(4);
  endtask

  task automatic wait_idle;
    for (int i = 0; i < 100 && status_one[0] !== 1'h0; i++) begin
      host.tick(1);
    end
    if (status_one[0] !== 1'h0) begin
      n_mismatch++;
      $display("BAD %0t update never finished", $time);
      finish_test();
    end
  endtask

  task automatic send(input logic [7:0] b);
    logic [3:0] q;
    for (int i = 7; i >= 0; i--) begin
      host.bit_cycle(b[i], 1'h1, q);
    end
  endtask

  task automatic recv(input logic quad, output logic [7:0] b);
    logic [3:0] q;
    for (int i = 0; i < (quad ? 2 : 8); i++) begin
      host.bit_cycle(1'h0, 1'h0, q);
      b = quad ? {b[3:0], q} : {b[6:0], q[1]};
    end
    chk_byte({4'h0, io_oe}, quad ? 8'h0F : 8'h02);
  endtask

  task automatic op(input logic [7:0] code, input int extra);
    logic [3:0] q;
    host.open_frame();
    send(code);
    repeat (extra) host.bit_cycle(1'h0, 1'h1, q);
    host.close_frame();
  endtask

  task automatic boot_write(input logic [31:0] w, input int nbits);
    logic [3:0] q;
    host.open_frame();
    send(fbr_pkg::BOOT_REG_WRITE_CMD);
    for (int i = 0; i < nbits; i++) begin
      host.bit_cycle(w[8 * (i / 8) + 7 - i % 8], 1'h1, q);
    end
    host.close_frame();
  endtask

  task automatic read_check(input logic [7:0] code, input int abytes, input logic [31:0] a);
    logic [7:0] b;
    host.open_frame();
    send(code);
    for (int i = abytes - 1; i >= 0; i--) begin
      send(a[8 * i +: 8]);
    end
    for (int i = 0; i < 4; i++) begin
      recv(1'h0, b);
      chk_byte(b, mem_byte(a[23:0] + 24'(i)));
    end
    host.close_frame();
  endtask

  // The host stays silent through the start delay and takes several bytes.
  task automatic boot_check(input logic quad);
    logic [3:0] q;
    logic [7:0] b;
    logic [31:0] start;
    start = {BOOT_ADDR, 9'h000};
    host.open_frame();
    repeat (BOOT_DELAY) host.bit_cycle(1'h0, 1'h0, q);
    for (int i = 0; i < 3; i++) begin
      recv(quad, b);
      chk_byte(b, mem_byte(start[23:0] + 24'(i)));
    end
    host.close_frame();
  endtask

  initial begin
    logic [31:0] w;
    logic [7:0] b;
    do_reset();
    boot_check(1'h0);
    host.open_frame();
    send(fbr_pkg::STATUS_READ_CMD);
    recv(1'h0, b);
    host.close_frame();
    chk_byte(b, 8'h00);
    host.open_frame();
    send(fbr_pkg::BOOT_REG_READ_CMD);
    for (int i = 0; i < 8; i++) begin
      recv(1'h0, b);
      chk_byte(b, BOOT_INIT[8 * (i % 4) +: 8]);
    end
    host.close_frame();
    op(fbr_pkg::SET_WRITE_LATCH_CMD, 0);
    chk_status(1'h1, 1'h0);
    op(fbr_pkg::CLEAR_WRITE_LATCH_CMD, 1);
    chk_status(1'h1, 1'h0);
    ext_busy = 1'h1;
    op(fbr_pkg::CLEAR_WRITE_LATCH_CMD, 0);
    chk_status(1'h1, 1'h0);
    ext_busy = 1'h0;
    op(fbr_pkg::CLEAR_WRITE_LATCH_CMD, 0);
    chk_status(1'h0, 1'h0);
    w = $random(seed);
    boot_write(w, 32);
    chk_word(boot_read_config, BOOT_INIT);
    op(fbr_pkg::SET_WRITE_LATCH_CMD, 0);
    boot_write(w, 31);
    chk_word(boot_read_config, BOOT_INIT);
    boot_write(w, 32);
    chk_status(1'h1, 1'h1);
    wait_idle();
    chk_status(1'h0, 1'h0);
    chk_word(boot_read_config, w);
    for (int k = 0; k < 2; k++) begin
      op(fbr_pkg::SET_WRITE_LATCH_CMD, 0);
      upd_erase_fail = (k == 0);
      upd_program_fail = (k == 1);
      boot_write($random(seed), 32);
      wait_idle();
      upd_erase_fail = 1'h0;
      upd_program_fail = 1'h0;
      ef_e = 1'h1;
      pf_e = (k == 1);
      chk_status(1'h0, 1'h0);
      chk_word(boot_read_config, w);
    end
    op(fbr_pkg::SET_WRITE_LATCH_CMD, 0);
    ext_busy = 1'h1;
    op(fbr_pkg::CLEAR_FAIL_FLAGS_CMD, 0);
    ext_busy = 1'h0;
    ef_e = 1'h0;
    pf_e = 1'h0;
    chk_status(1'h1, 1'h0);
    read_check(fbr_pkg::READ_CMD, 3, 32'h00FFFFFE);
    four_byte_address_mode = 1'h1;
    read_check(fbr_pkg::READ_CMD, 4, $random(seed));
    four_byte_address_mode = 1'h0;
    read_check(fbr_pkg::FOUR_BYTE_READ_CMD, 4, $random(seed));
    quad_enable = 1'h1;
    do_reset();
    boot_check(1'h1);
    finish_test();
  end
endmodule

`default_nettype wire
